// ### bench/cms_host_model.sv
// host model issuing direct commands over the link
`timescale 1ns/1ps
module cms_host_model (
  // bench request
  input wire logic sendReq,
  input wire logic [3:0] sendCode,
  input wire logic linkRstReq,
  // link side
  output logic linkClk,
  output logic linkRst,
  output logic cmdStrobe,
  output logic [3:0] cmdCode
);
  // ****************************************
  // frames
  // ****************************************
  task automatic tick;
    #32 linkClk = 1'b1;
    #32 linkClk = 1'b0;
  endtask : tick
  initial begin
    linkClk = 1'b0;
    linkRst = 1'b1;
    cmdStrobe = 1'b0;
    cmdCode = 4'hF;
    // clock only runs in frames, so reset gets its own edges
    repeat (2) tick();
    linkRst = 1'b0;
  end
  // one strobe per frame; bench waits for completion, never chains
  always @(sendReq) begin
    if (linkRst === 1'b0) begin
      #5 cmdCode = sendCode;
      cmdStrobe = 1'b1;
      tick();
      cmdStrobe = 1'b0;
      cmdCode = ~sendCode;
      tick();
      tick();
    end
  end
  // serial interface reset in mid-run, one link edge long
  always @(linkRstReq) begin
    if (linkRst === 1'b0) begin
      linkRst = 1'b1;
      tick();
      linkRst = 1'b0;
    end
  end
endmodule : cms_host_model

// ### bench/cms_seq_tb.sv
// self-checking bench of the command sequencer
`timescale 1ns/1ps
module cms_seq_tb
  import cms_pkg::*;
;
  // ****************************************
  // signals and models
  // ****************************************
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic linkClk, linkRst, cmdStrobe, sendReq, serSelN, trackDepth, linkRstReq;
  logic [3:0] cmdCode, sendCode, rssiLevel, regStep, trimCap, rssiDisplay, hrAt;
  cms_cfg_t cfg;
  cms_afe_t afe, afeOr, afeAtStart;
  logic [7:0] modDepthTarget, adcData, adcOut, modDepth, adcVal;
  logic headroomOk, tankResonant, adcValid, csCalDone, csMeasDone, rxOn;
  logic modDepthWrite, adcStart, csCalStart, csMeasStart;
  logic transparentMode, testAccess, cmdDone, cmdRejected, busy;
  logic [2:0] adcDly, calDly, measDly;
  int nMismatch, nCompared, nDone, nRej, nWr, doneCnt, rejCnt, cyc, tick;

  always #12.5 sys_clk = ~sys_clk;

  cms_seq #(.REG_SETTLE(20), .REG_LIMIT(400), .MOD_LIMIT(300), .ANT_LIMIT(300),
    .CSCAL_LIMIT(300)) i_cms_seq (
    .sys_clk, .sys_rst, .linkClk, .linkRst, .cmdStrobe, .cmdCode, .serSelN, .cfg,
    .modDepthTarget, .headroomOk, .tankResonant, .adcValid, .adcData, .csCalDone,
    .csMeasDone, .rxOn, .rssiLevel, .afe, .regStep, .modDepth, .modDepthWrite,
    .trimCap, .adcStart, .csCalStart, .csMeasStart, .adcOut, .rssiDisplay,
    .transparentMode, .testAccess, .cmdDone, .cmdRejected, .busy);
  cms_host_model i_cms_host_model (.sendReq, .sendCode, .linkRstReq, .linkClk, .linkRst,
    .cmdStrobe, .cmdCode);

  // analog side answers a few cycles after each start pulse
  assign headroomOk = (regStep >= hrAt);
  assign tankResonant = (trimCap == 4'h5);
  always @(posedge sys_clk) begin
    adcDly <= {adcDly[1:0], adcStart === 1'b1};
    calDly <= {calDly[1:0], csCalStart === 1'b1};
    measDly <= {measDly[1:0], csMeasStart === 1'b1};
    adcValid <= adcDly[2];
    csCalDone <= calDly[2];
    csMeasDone <= measDly[2];
    adcData <= (adcDly[2] | measDly[2]) ? (trackDepth ? {modDepth[6:0], 1'b0} : adcVal)
      : ~adcVal;
  end

  // settled sampling away from the launching edge
  always @(negedge sys_clk) begin
    if (cmdDone === 1'b1) nDone++;
    if (cmdRejected === 1'b1) nRej++;
    if (cmdDone === 1'b1 && modDepthWrite === 1'b1) nWr++;
    if (adcStart === 1'b1) afeAtStart = afe;
    if (busy === 1'b1) afeOr = afeOr | afe;
    tick++;
    if (tick == 30000) begin
      nMismatch++;
      conclude();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic waitc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : waitc

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic conclude;
    $display("compared %0d mismatched %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  // sends one code and waits for its end, bounded by lim plus 20 cycles
  task automatic run(input logic [3:0] code, input int lim);
    int d0;
    int r0;
    d0 = nDone;
    r0 = nRej;
    afeOr = '0;
    cyc = 0;
    @(posedge sys_clk);
    sendCode <= code;
    sendReq <= ~sendReq;
    while (nDone == d0 && nRej == r0 && cyc < lim + 20) begin
      @(posedge sys_clk);
      cyc++;
    end
    waitc(4);
    doneCnt = nDone - d0;
    rejCnt = nRej - r0;
  endtask : run

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_refuse;
    @(posedge sys_clk);
    cfg.oscEn <= 1'b0;
    run(CMD_MEAS_PHASE, 0);
    chk("osc rej", rejCnt, 1);
    chk("osc done", doneCnt, 0);
    @(posedge sys_clk);
    cfg.oscEn <= 1'b1;
    cfg.xtalStable <= 1'b0;
    run(CMD_CLR_RSSI, 0);
    chk("xtal rej", rejCnt, 1);
    @(posedge sys_clk);
    cfg.xtalStable <= 1'b1;
    cfg.regExtSel <= 1'b1;
    hrAt <= 4'h3;
    run(CMD_ADJ_REG, 0);
    chk("ext rej", rejCnt, 1);
    chk("ext step", regStep, REG_TOP);
    @(posedge sys_clk);
    cfg.regExtSel <= 1'b0;
    cfg.csManualCal <= 4'h3;
    run(CMD_CAL_CS, 0);
    chk("manual rej", rejCnt, 1);
    @(posedge sys_clk);
    cfg.csManualCal <= 4'h0;
  endtask : t_refuse

  task automatic t_phase;
    logic [7:0] codes [3] = '{8'hFF, 8'h00, 8'h80};
    foreach (codes[i]) begin
      adcVal = codes[i];
      run(CMD_MEAS_PHASE, CONV_MAX_CYC);
      chk("phase code", adcOut, codes[i]);
      chk("phase done", doneCnt, 1);
      chk("phase time", cyc < CONV_MAX_CYC, 1);
    end
    chk("phase afe", afeAtStart & 10'h2BC, 10'h2A4);
  endtask : t_phase

  task automatic t_supply;
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk);
      cfg.supplySel <= cms_sup_t'(s);
      adcVal = 8'h20 + 8'(s);
      run(CMD_MEAS_SUPPLY, CONV_MAX_CYC);
      chk("supply sel", afeAtStart.supplyMux, s);
      chk("supply afe", afeAtStart & 10'h07C, 10'h04C);
      chk("supply code", adcOut, adcVal);
      chk("supply done", doneCnt, 1);
    end
  endtask : t_supply

  task automatic t_adj;
    logic [3:0] at [4] = '{4'h3, 4'hF, 4'h0, 4'hF};
    logic [3:0] ex [4] = '{4'h3, REG_FLOOR_5V, REG_TOP, REG_FLOOR_3V3};
    foreach (at[i]) begin
      @(posedge sys_clk);
      hrAt <= at[i];
      cfg.supply3v3 <= (i == 3);
      run(CMD_ADJ_REG, 400);
      chk("reg step", regStep, ex[i]);
      chk("reg time", cyc < 400, 1);
      chk("reg load", {afeOr.txEn, afeOr.rxEn}, 2'b11);
      chk("reg done", doneCnt, 1);
    end
  endtask : t_adj

  task automatic t_calib;
    @(posedge sys_clk);
    modDepthTarget <= 8'h10;
    trackDepth = 1'b1;
    run(CMD_CAL_MOD, 300);
    trackDepth = 1'b0;
    chk("depth value", modDepth, 8'h08);
    chk("depth write", nWr, 1);
    chk("depth time", cyc < 300, 1);
    run(CMD_CAL_ANT, 300);
    chk("trim value", trimCap, 4'h5);
    chk("trim time", cyc < 300, 1);
    @(posedge sys_clk);
    cfg.oscEn <= 1'b0;
    run(CMD_CAL_CS, 300);
    chk("cs cal done", doneCnt, 1);
    adcVal = 8'h5A;
    run(CMD_MEAS_CAP, 300);
    chk("cap code", adcOut, 8'h5A);
    chk("cap done", doneCnt, 1);
    @(posedge sys_clk);
    cfg.oscEn <= 1'b1;
  endtask : t_calib

  task automatic t_rssi;
    @(posedge sys_clk);
    rssiLevel <= 4'h6;
    rxOn <= 1'b1;
    waitc(3);
    @(posedge sys_clk);
    rxOn <= 1'b0;
    rssiLevel <= 4'h2;
    waitc(3);
    @(posedge sys_clk);
    rxOn <= 1'b1;
    waitc(3);
    chk("rssi restart", rssiDisplay, 4'h2);
    @(posedge sys_clk);
    rssiLevel <= 4'h7;
    waitc(3);
    @(posedge sys_clk);
    rssiLevel <= 4'h3;
    run(CMD_CLR_RSSI, 0);
    chk("rssi clear", rssiDisplay, 4'h3);
    chk("rssi irq", doneCnt, 0);
  endtask : t_rssi

  task automatic t_modes;
    int r0;
    run(CMD_TRANSPARENT, 0);
    chk("transp wait", transparentMode, 0);
    @(posedge sys_clk);
    serSelN <= 1'b1;
    waitc(6);
    chk("transp on", transparentMode, 1);
    @(posedge sys_clk);
    serSelN <= 1'b0;
    waitc(6);
    chk("transp off", transparentMode, 0);
    run(CMD_TEST_ACCESS, 0);
    chk("test access", testAccess, 1);
    r0 = nRej;
    @(posedge sys_clk);
    linkRstReq <= ~linkRstReq;
    waitc(12);
    chk("test kept", testAccess, 1);
    chk("link rst quiet", nRej - r0, 0);
  endtask : t_modes

  initial begin
    {sendReq, serSelN, rxOn, trackDepth, adcValid, csCalDone, csMeasDone, linkRstReq} = '0;
    {sendCode, rssiLevel, hrAt, modDepthTarget, adcVal, adcData} = '0;
    {adcDly, calDly, measDly} = '0;
    afeOr = '0;
    cfg = '0;
    cfg.oscEn = 1'b1;
    cfg.xtalStable = 1'b1;
    waitc(5);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    waitc(8);
    chk("reset idle", {busy, regStep, adcOut, testAccess, afe}, '0);
    t_refuse();
    t_phase();
    t_supply();
    t_adj();
    t_calib();
    t_rssi();
    t_modes();
    conclude();
  end
endmodule : cms_seq_tb

// ### design/cms_pkg.sv
// shared constants and types of the calibration and measurement command sequencer
package cms_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 40;
  localparam int REG_SETTLE_US = 300;
  localparam int REG_SETTLE_CYC = REG_SETTLE_US * CLK_MHZ;
  localparam int REG_MAX_US = 5000;
  localparam int REG_MAX_CYC = REG_MAX_US * CLK_MHZ;
  localparam int MOD_MAX_US = 275;
  localparam int MOD_MAX_CYC = MOD_MAX_US * CLK_MHZ;
  localparam int ANT_MAX_US = 250;
  localparam int ANT_MAX_CYC = ANT_MAX_US * CLK_MHZ;
  localparam int CONV_MAX_US = 25;
  localparam int CONV_MAX_CYC = CONV_MAX_US * CLK_MHZ;
  localparam int CSCAL_MAX_US = 3000;
  localparam int CSCAL_MAX_CYC = CSCAL_MAX_US * CLK_MHZ;
  localparam int CAP_MAX_US = 250;
  localparam int CAP_MAX_CYC = CAP_MAX_US * CLK_MHZ;
  localparam int STEP_WAIT_CYC = 16;

  // ****************************************
  // regulator steps below the top level
  // ****************************************
  localparam logic [3:0] REG_TOP = 4'h0;
  // 5.1 V down to 3.9 V in 120 mV steps
  localparam logic [3:0] REG_FLOOR_5V = 4'hA;
  localparam logic [3:0] REG_FLOOR_3V3 = 4'h7;
  localparam logic [3:0] CODE_IGNORED = 4'hF;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    CMD_ADJ_REG, CMD_CAL_MOD, CMD_CAL_ANT, CMD_MEAS_PHASE, CMD_CLR_RSSI,
    CMD_TRANSPARENT, CMD_CAL_CS, CMD_MEAS_CAP, CMD_MEAS_SUPPLY, CMD_TEST_ACCESS
  } cms_cmd_t;

  typedef enum logic [1:0] {SUP_MAIN, SUP_ANALOG, SUP_DIGITAL, SUP_RF} cms_sup_t;

  typedef enum logic [2:0] {MUX_NONE, MUX_PHASE, MUX_DEPTH, MUX_SUPPLY} cms_mux_t;

  typedef struct packed {
    logic txEn;
    logic rxEn;
    logic phaseDetEn;
    logic divEn;
    logic adcRelative;
    cms_mux_t adcMux;
    cms_sup_t supplyMux;
  } cms_afe_t;

  typedef struct packed {
    logic oscEn;
    logic xtalStable;
    logic regExtSel;
    logic supply3v3;
    cms_sup_t supplySel;
    logic [3:0] csManualCal;
  } cms_cfg_t;

endpackage : cms_pkg

// ### design/cms_seq.sv
// command sequencer for calibration and measurement direct commands
`timescale 1ns/1ps

module cms_seq
  import cms_pkg::*;
#(
  parameter int TRIM_W = 4,
  parameter int REG_SETTLE = REG_SETTLE_CYC,
  parameter int REG_LIMIT = REG_MAX_CYC,
  parameter int MOD_LIMIT = MOD_MAX_CYC,
  parameter int ANT_LIMIT = ANT_MAX_CYC,
  parameter int CSCAL_LIMIT = CSCAL_MAX_CYC,
  parameter int CAP_LIMIT = CAP_MAX_CYC
) (
  // system clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // serial link side
  input wire logic linkClk,
  input wire logic linkRst,
  input wire logic cmdStrobe,
  input wire logic [3:0] cmdCode,
  input wire logic serSelN,
  // configuration bits
  input wire cms_cfg_t cfg,
  input wire logic [7:0] modDepthTarget,
  // analog status
  input wire logic headroomOk,
  input wire logic tankResonant,
  input wire logic adcValid,
  input wire logic [7:0] adcData,
  input wire logic csCalDone,
  input wire logic csMeasDone,
  input wire logic rxOn,
  input wire logic [3:0] rssiLevel,
  // analog control
  output cms_afe_t afe,
  output logic [3:0] regStep,
  output logic [7:0] modDepth,
  output logic modDepthWrite,
  output logic [TRIM_W-1:0] trimCap,
  output logic adcStart,
  output logic csCalStart,
  output logic csMeasStart,
  // results and status
  output logic [7:0] adcOut,
  output logic [3:0] rssiDisplay,
  output logic transparentMode,
  output logic testAccess,
  output logic cmdDone,
  output logic cmdRejected,
  output logic busy
);

  typedef enum logic [2:0] {
    S_IDLE, S_SETTLE, S_REG_CHECK, S_CONV, S_ANT_CHECK, S_CS_WAIT, S_DONE
  } cms_state_t;

  cms_state_t state;
  cms_cmd_t curCmd;
  cms_cmd_t cmdIn;
  logic [3:0] linkCode;
  logic linkTgl;
  logic [2:0] tglSync;
  logic [1:0] selSync;
  logic selPrev;
  logic [1:0] hdSync;
  logic [1:0] tankSync;
  logic cmdNew;
  logic codeValid;
  logic cmdOk;
  logic startLong;
  logic timeUp;
  logic [13:0] waitCnt;
  logic [17:0] elapsed;
  logic [17:0] limit;
  logic [3:0] regFloor;
  logic regEnd;
  logic modHit;
  logic antHit;
  logic transpArmed;
  logic rxOnPrev;
  logic rssiClr;

  function automatic logic needs_osc(cms_cmd_t c);
    return !(c inside {CMD_CAL_CS, CMD_MEAS_CAP, CMD_TEST_ACCESS});
  endfunction : needs_osc

  function automatic logic is_long(cms_cmd_t c);
    return !(c inside {CMD_CLR_RSSI, CMD_TRANSPARENT, CMD_TEST_ACCESS});
  endfunction : is_long

  function automatic logic [17:0] limit_of(cms_cmd_t c);
    unique case (c)
      CMD_ADJ_REG: return 18'(REG_LIMIT);
      CMD_CAL_MOD: return 18'(MOD_LIMIT);
      CMD_CAL_ANT: return 18'(ANT_LIMIT);
      CMD_CAL_CS: return 18'(CSCAL_LIMIT);
      CMD_MEAS_CAP: return 18'(CAP_LIMIT);
      default: return 18'(CONV_MAX_CYC);
    endcase
  endfunction : limit_of

  // ****************************************
  // link domain: command capture
  // ****************************************
  // code stays put until the next strobe or link reset, so the toggle alone crosses
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      linkCode <= CODE_IGNORED;
      linkTgl <= 1'b0;
    end else if (cmdStrobe) begin
      linkCode <= cmdCode;
      linkTgl <= ~linkTgl;
    end
  end

  // ****************************************
  // crossings and pin synchronisers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tglSync <= 3'h0;
      selSync <= 2'h0;
      selPrev <= 1'b0;
      hdSync <= 2'h0;
      tankSync <= 2'h0;
    end else begin
      tglSync <= {tglSync[1:0], linkTgl};
      selSync <= {selSync[0], serSelN};
      selPrev <= selSync[1];
      hdSync <= {hdSync[0], headroomOk};
      tankSync <= {tankSync[0], tankResonant};
    end
  end

  // ****************************************
  // acceptance
  // ****************************************
  always_comb begin
    cmdIn = cms_cmd_t'(linkCode);
    cmdNew = tglSync[2] ^ tglSync[1];
    codeValid = linkCode <= 4'(CMD_TEST_ACCESS);
    cmdOk = codeValid;
    if (needs_osc(cmdIn) && !(cfg.oscEn && cfg.xtalStable)) begin
      cmdOk = 1'b0;
    end
    if (cmdIn == CMD_ADJ_REG && cfg.regExtSel) begin
      cmdOk = 1'b0;
    end
    if (cmdIn == CMD_CAL_CS && cfg.csManualCal != 4'h0) begin
      cmdOk = 1'b0;
    end
    if (is_long(cmdIn) && state != S_IDLE) begin
      cmdOk = 1'b0;
    end
    // stray link resets decode as an ignored code, never as a command
    cmdRejected = cmdNew && codeValid && !cmdOk;
    startLong = cmdNew && cmdOk && is_long(cmdIn);
    rssiClr = cmdNew && cmdOk && cmdIn == CMD_CLR_RSSI;
    // three cycles early, so the termination pulse itself still lands inside the limit
    timeUp = elapsed >= limit - 18'd3;
    regFloor = cfg.supply3v3 ? REG_FLOOR_3V3 : REG_FLOOR_5V;
    regEnd = hdSync[1] || regStep >= regFloor;
    modHit = adcData == modDepthTarget || modDepth == 8'h00 || modDepth == 8'hFF;
    antHit = tankSync[1] || &trimCap;
    busy = state != S_IDLE;
  end

  // ****************************************
  // sequence control
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= S_IDLE;
      curCmd <= CMD_ADJ_REG;
      waitCnt <= 14'h0;
      elapsed <= 18'h0_0000;
      limit <= 18'h0_0000;
      adcStart <= 1'b0;
      csCalStart <= 1'b0;
      csMeasStart <= 1'b0;
      cmdDone <= 1'b0;
    end else begin
      adcStart <= 1'b0;
      csCalStart <= 1'b0;
      csMeasStart <= 1'b0;
      cmdDone <= 1'b0;
      elapsed <= elapsed + 18'd1;
      waitCnt <= (waitCnt != 14'h0) ? waitCnt - 14'd1 : 14'h0;
      if (state != S_IDLE && state != S_DONE && timeUp) begin
        state <= S_DONE;
      end else begin
        unique case (state)
          S_IDLE: if (startLong) begin
            curCmd <= cmdIn;
            elapsed <= 18'h0_0000;
            limit <= limit_of(cmdIn);
            unique case (cmdIn)
              CMD_ADJ_REG: begin
                waitCnt <= 14'(REG_SETTLE);
                state <= S_SETTLE;
              end
              CMD_CAL_MOD, CMD_CAL_ANT: begin
                waitCnt <= 14'(STEP_WAIT_CYC);
                state <= S_SETTLE;
              end
              CMD_CAL_CS: begin
                csCalStart <= 1'b1;
                state <= S_CS_WAIT;
              end
              CMD_MEAS_CAP: begin
                csMeasStart <= 1'b1;
                state <= S_CS_WAIT;
              end
              default: begin
                adcStart <= 1'b1;
                state <= S_CONV;
              end
            endcase
          end
          S_SETTLE: if (waitCnt == 14'h0) begin
            if (curCmd == CMD_ADJ_REG) begin
              state <= S_REG_CHECK;
            end else if (curCmd == CMD_CAL_MOD) begin
              adcStart <= 1'b1;
              state <= S_CONV;
            end else begin
              state <= S_ANT_CHECK;
            end
          end
          S_REG_CHECK: if (regEnd) begin
            state <= S_DONE;
          end else begin
            waitCnt <= 14'(REG_SETTLE);
            state <= S_SETTLE;
          end
          S_CONV: if (adcValid) begin
            if (curCmd == CMD_CAL_MOD && !modHit) begin
              waitCnt <= 14'(STEP_WAIT_CYC);
              state <= S_SETTLE;
            end else begin
              state <= S_DONE;
            end
          end
          S_ANT_CHECK: if (antHit) begin
            state <= S_DONE;
          end else begin
            waitCnt <= 14'(STEP_WAIT_CYC);
            state <= S_SETTLE;
          end
          S_CS_WAIT: begin
            if ((curCmd == CMD_CAL_CS && csCalDone) || (curCmd == CMD_MEAS_CAP && csMeasDone)) begin
              state <= S_DONE;
            end
          end
          S_DONE: begin
            cmdDone <= 1'b1;
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // regulator level
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      regStep <= REG_TOP;
    end else if (state == S_IDLE && startLong && cmdIn == CMD_ADJ_REG) begin
      regStep <= REG_TOP;
    end else if (state == S_REG_CHECK && !regEnd && !timeUp) begin
      regStep <= regStep + 4'd1;
    end
  end

  // ****************************************
  // modulation depth and antenna trim
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      modDepth <= 8'h00;
      modDepthWrite <= 1'b0;
    end else begin
      modDepthWrite <= state == S_DONE && curCmd == CMD_CAL_MOD;
      if (state == S_IDLE && startLong && cmdIn == CMD_CAL_MOD) begin
        modDepth <= modDepthTarget;
      end else if (state == S_CONV && adcValid && curCmd == CMD_CAL_MOD && !modHit) begin
        modDepth <= (adcData < modDepthTarget) ? modDepth + 8'd1 : modDepth - 8'd1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      trimCap <= '0;
    end else if (state == S_IDLE && startLong && cmdIn == CMD_CAL_ANT) begin
      trimCap <= '0;
    end else if (state == S_ANT_CHECK && !antHit && !timeUp) begin
      trimCap <= trimCap + TRIM_W'(1);
    end
  end

  // ****************************************
  // converter result
  // ****************************************
  // the converter clamps the detector range itself, so the code is kept raw
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      adcOut <= 8'h00;
    end else if (state == S_CONV && adcValid && curCmd != CMD_CAL_MOD) begin
      adcOut <= adcData;
    end else if (state == S_CS_WAIT && curCmd == CMD_MEAS_CAP && csMeasDone) begin
      adcOut <= adcData;
    end
  end

  // ****************************************
  // analog front end control
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      afe <= '0;
    end else if (state == S_IDLE && startLong) begin
      afe <= '0;
      afe.supplyMux <= cfg.supplySel;
      unique case (cmdIn)
        CMD_ADJ_REG: begin
          afe.txEn <= 1'b1;
          afe.rxEn <= 1'b1;
        end
        CMD_CAL_MOD: begin
          afe.txEn <= 1'b1;
          afe.adcMux <= MUX_DEPTH;
        end
        CMD_CAL_ANT: afe.txEn <= 1'b1;
        CMD_MEAS_PHASE: begin
          afe.txEn <= 1'b1;
          afe.phaseDetEn <= 1'b1;
          afe.adcRelative <= 1'b1;
          afe.adcMux <= MUX_PHASE;
        end
        CMD_MEAS_SUPPLY: begin
          afe.divEn <= 1'b1;
          afe.adcMux <= MUX_SUPPLY;
        end
        default: afe.txEn <= 1'b0;
      endcase
    end else if (state == S_DONE) begin
      afe <= '0;
    end
  end

  // ****************************************
  // rssi peak hold
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rssiDisplay <= 4'h0;
      rxOnPrev <= 1'b0;
    end else begin
      rxOnPrev <= rxOn;
      if ((rxOn && !rxOnPrev) || rssiClr) begin
        rssiDisplay <= 4'h0;
      end else if (rxOn && rssiLevel > rssiDisplay) begin
        rssiDisplay <= rssiLevel;
      end
    end
  end

  // ****************************************
  // transparent mode and test access
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      transpArmed <= 1'b0;
      transparentMode <= 1'b0;
    end else begin
      if (cmdNew && cmdOk && cmdIn == CMD_TRANSPARENT) begin
        transpArmed <= 1'b1;
      end else if (selSync[1] && !selPrev && transpArmed) begin
        transpArmed <= 1'b0;
      end
      // select low always ends the mode, even when a new code lands in the same cycle
      if (selSync[1] && !selPrev && transpArmed) begin
        transparentMode <= 1'b1;
      end else if (!selSync[1]) begin
        transparentMode <= 1'b0;
      end
    end
  end

  // only the system reset clears it; link resets never reach here
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      testAccess <= 1'b0;
    end else if (cmdNew && cmdOk && cmdIn == CMD_TEST_ACCESS) begin
      testAccess <= 1'b1;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence regStepSeq;
    state == S_REG_CHECK && !regEnd && !timeUp;
  endsequence

  sequence phaseConvSeq;
    state == S_CONV && curCmd == CMD_MEAS_PHASE && adcValid;
  endsequence

  chk_reg_start_max: assert property (state == S_IDLE && startLong && cmdIn == CMD_ADJ_REG
      |=> regStep == REG_TOP && afe.txEn && afe.rxEn)
    else $error("regulator adjust did not start at top level");
  chk_reg_step_down: assert property (regStepSeq |=> regStep == $past(regStep) + 4'd1
      && state == S_SETTLE && waitCnt == 14'(REG_SETTLE))
    else $error("regulator did not step down with a new settle");
  chk_reg_floor_held: assert property (busy && curCmd == CMD_ADJ_REG |-> regStep <= regFloor)
    else $error("regulator went below floor");
  chk_run_time_bound: assert property (busy |-> elapsed < limit)
    else $error("command ran past its time limit");
  chk_ext_reg_refuse: assert property (cmdNew && cmdIn == CMD_ADJ_REG && cfg.regExtSel
      |-> !startLong && (state != S_IDLE || cmdRejected))
    else $error("regulator adjust accepted under external definition");
  chk_osc_gate: assert property (startLong && needs_osc(cmdIn) |-> cfg.oscEn && cfg.xtalStable)
    else $error("command accepted without stable oscillator");
  chk_done_pulse: assert property (state == S_DONE |=> cmdDone ##1 !cmdDone)
    else $error("termination pulse missing or stretched");
  chk_rssi_no_irq: assert property (rssiClr && state == S_IDLE |=> !cmdDone && state == S_IDLE)
    else $error("rssi clear raised a termination pulse");
  chk_phase_store: assert property (phaseConvSeq |=> adcOut == $past(adcData) ##1 cmdDone)
    else $error("phase result not stored before termination");
  chk_rssi_clear_zero: assert property ((rxOn && !rxOnPrev) || rssiClr |=> rssiDisplay == 4'h0)
    else $error("rssi display not cleared");
  chk_transp_level: assert property (transparentMode |-> $past(selSync[1]))
    else $error("transparent mode held without select high");
  chk_cs_manual_block: assert property (cmdNew && cmdIn == CMD_CAL_CS && cfg.csManualCal != 4'h0
      |=> !csCalStart)
    else $error("capacitive calibration ran with manual bits set");
  chk_refuse_quiet: assert property (cmdRejected && state == S_IDLE
      |=> state == S_IDLE && !cmdDone && $stable(regStep) && $stable(adcOut))
    else $error("refused command changed state");

endmodule : cms_seq
